// file: core/lcd_device_end.sv
// Behaviour
// - id 110, address, device returns nibble D0 first
// - id 101, address, nibble stored D0 first
// - 101 frame: read stored nibble, then overwrite
// - six-bit address msb first, four-bit data
// - 0000-0000 stops oscillator and bias; default
// - 0000-0001 starts the oscillator
// - 0000-0010 bias off, 0000-0011 bias on
// - 0000-0100/0110 time base output off/on
// - 0000-0101/0111 watchdog flag off/on
// - 0000-1000/1001 tone outputs off/on
// - 0000-11xx clears time base counter
// - 0000-111x clears watchdog stage
// - 0001-01/10/11 crystal, internal, external source
// - 0010-abXc: bias half/third, ab commons
// - 010 tone 4 kHz, 011 tone 2 kHz
// - 101X-Xnnn sets rate 2^nnn Hz
// - 1110-0000 factory mode, 1110-0011 normal
// - host samples after read strobe rises
// - id 100 once, then commands back to back
// - host reinitialises all settings after power-up
`timescale 1ns/10ps
`default_nettype none
module lcd_device_end (
   input wire logic pclk,
   input wire logic presetn,
   lcd_link_if.dev link,
   input wire logic [5:0] disp_addr,
   output logic [3:0] disp_nibble,
   output var lcd_pkg::lcd_cfg_type cfg,
   output logic timebase_clear,
   output logic watchdog_clear
);
   typedef enum logic [2:0] {
      PH_ID, PH_ADDR, PH_READ, PH_WRITE, PH_CMD, PH_SKIP
   } lcd_phase_type;

   typedef struct packed {
      lcd_phase_type ph;
      logic is_read;
      logic [3:0] cnt;
      logic [8:0] sh;
      logic [5:0] addr;
      logic [1:0] ri;
      logic wr_p;
      logic rd_p;
      logic dout;
      logic doe;
      lcd_pkg::lcd_cfg_type cfg;
      logic tb_clr;
      logic wd_clr;
      logic [3:0] disp;
      logic [63:0][3:0] ram;
   } lcd_dev_state_type;

   lcd_dev_state_type r_reg;
   lcd_dev_state_type r_next;
   logic [3:0] pins;
   logic cs_s;
   logic wr_s;
   logic rd_s;
   logic din;
   logic wr_rise;
   logic wr_fall;
   logic rd_fall;
   logic [8:0] code;

   lcd_sync #(.W(4)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({link.cs_n, link.wr_n, link.rd_n, link.data_line}),
      .init(4'hF),
      .q(pins)
   );

   assign cs_s = pins[3];
   assign wr_s = pins[2];
   assign rd_s = pins[1];
   assign din = pins[0];
   assign wr_rise = wr_s & ~r_reg.wr_p;
   assign wr_fall = ~wr_s & r_reg.wr_p;
   assign rd_fall = ~rd_s & r_reg.rd_p;
   assign code = {r_reg.sh[7:0], din};

   function automatic lcd_pkg::lcd_cfg_type cmd_apply(
      input lcd_pkg::lcd_cfg_type c,
      input logic [8:0] k
   );
      lcd_pkg::lcd_cfg_type o;
      logic [7:0] b;
      o = c;
      b = k[8:1];
      unique case (b)
         lcd_pkg::CMD_SYS_OFF: begin
            o.osc_on = 1'b0;
            o.bias_on = 1'b0;
         end
         lcd_pkg::CMD_OSC_ON: o.osc_on = 1'b1;
         lcd_pkg::CMD_BIAS_OFF: o.bias_on = 1'b0;
         lcd_pkg::CMD_BIAS_ON: o.bias_on = 1'b1;
         lcd_pkg::CMD_TB_OFF: o.tb_out_en = 1'b0;
         lcd_pkg::CMD_TB_ON: o.tb_out_en = 1'b1;
         lcd_pkg::CMD_WD_OFF: o.wd_flag_en = 1'b0;
         lcd_pkg::CMD_WD_ON: o.wd_flag_en = 1'b1;
         lcd_pkg::CMD_TONE_OFF: o.tone_on = 1'b0;
         lcd_pkg::CMD_TONE_ON: o.tone_on = 1'b1;
         lcd_pkg::CMD_FACTORY: o.factory = 1'b1;
         lcd_pkg::CMD_NORMAL: o.factory = 1'b0;
         default: begin
         end
      endcase
      // group 0001-00xx selects nothing and is ignored
      if (b[7:4] == lcd_pkg::GRP_SOURCE && b[3:2] != 2'h0) begin
         o.src = b[3:2];
      end
      // ab=11 has no meaning; the common count is left alone
      if (b[7:4] == lcd_pkg::GRP_BIAS && b[3:2] != lcd_pkg::COMMONS_BAD) begin
         o.commons = b[3:2];
         o.bias_third = b[0];
      end
      if (b[7:5] == lcd_pkg::GRP_TONE_HIGH) begin
         o.tone_high = 1'b1;
      end
      if (b[7:5] == lcd_pkg::GRP_TONE_LOW) begin
         o.tone_high = 1'b0;
      end
      if (b[7:5] == lcd_pkg::GRP_IRQ) begin
         o.irq_en = b[3];
      end
      if (b[7:5] == lcd_pkg::GRP_RATE) begin
         o.rate = b[2:0];
      end
      return o;
   endfunction

   always_comb begin
      r_next = r_reg;
      r_next.tb_clr = 1'b0;
      r_next.wd_clr = 1'b0;
      r_next.wr_p = wr_s;
      r_next.rd_p = rd_s;
      r_next.disp = r_reg.ram[disp_addr];
      if (cs_s) begin
         // chip select high ends or aborts any frame
         r_next.ph = PH_ID;
         r_next.cnt = 4'h0;
         r_next.doe = 1'b0;
      end else begin
         // host takes the line back on its first write strobe
         if (wr_fall) begin
            r_next.doe = 1'b0;
         end
         if (wr_rise) begin
            r_next.sh = code;
            r_next.cnt = r_reg.cnt + 4'h1;
            unique case (r_reg.ph)
               PH_ID: begin
                  if (r_reg.cnt == lcd_pkg::ID_LAST_BIT) begin
                     r_next.cnt = 4'h0;
                     r_next.is_read = (code[2:0] == lcd_pkg::ID_READ);
                     if (code[2:0] == lcd_pkg::ID_READ ||
                         code[2:0] == lcd_pkg::ID_WRITE) begin
                        r_next.ph = PH_ADDR;
                     end else if (code[2:0] == lcd_pkg::ID_CMD) begin
                        r_next.ph = PH_CMD;
                     end else begin
                        r_next.ph = PH_SKIP;
                     end
                  end
               end
               PH_ADDR: begin
                  if (r_reg.cnt == lcd_pkg::ADDR_LAST_BIT) begin
                     r_next.addr = code[5:0];
                     r_next.cnt = 4'h0;
                     r_next.ri = 2'h0;
                     r_next.ph = r_reg.is_read ? PH_READ : PH_WRITE;
                  end
               end
               PH_WRITE: begin
                  if (r_reg.cnt == lcd_pkg::NIB_LAST_BIT) begin
                     // bits arrive D0 first
                     r_next.ram[r_reg.addr] =
                        {din, r_reg.sh[0], r_reg.sh[1], r_reg.sh[2]};
                     r_next.addr = r_reg.addr + 6'h01;
                     r_next.cnt = 4'h0;
                     r_next.ri = 2'h0;
                  end
               end
               PH_CMD: begin
                  if (r_reg.cnt == lcd_pkg::CMD_LAST_BIT) begin
                     r_next.cfg = cmd_apply(r_reg.cfg, code);
                     r_next.tb_clr =
                        (code[8:3] == lcd_pkg::GRP_TB_CLEAR);
                     r_next.wd_clr =
                        (code[8:2] == lcd_pkg::GRP_WD_CLEAR);
                     // stays in command phase for the next code
                     r_next.cnt = 4'h0;
                  end
               end
               PH_READ, PH_SKIP: begin
                  r_next.cnt = r_reg.cnt;
               end
            endcase
         end
         if (rd_fall && (r_reg.ph == PH_READ || r_reg.ph == PH_WRITE)) begin
            // bit stands until the next read strobe falls
            r_next.doe = 1'b1;
            r_next.dout = r_reg.ram[r_reg.addr][r_reg.ri];
            r_next.ri = r_reg.ri + 2'h1;
            if (r_reg.ph == PH_READ && r_reg.ri == lcd_pkg::NIB_LAST_IDX) begin
               r_next.addr = r_reg.addr + 6'h01;
            end
         end
      end
   end

   // ram content has no reset value; it is cleared for determinism only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
         r_reg.wr_p <= 1'b1;
         r_reg.rd_p <= 1'b1;
         r_reg.cfg <= lcd_pkg::CFG_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign link.dev_data_o = r_reg.dout;
   assign link.dev_data_oe = r_reg.doe;
   assign disp_nibble = r_reg.disp;
   assign cfg = r_reg.cfg;
   assign timebase_clear = r_reg.tb_clr;
   assign watchdog_clear = r_reg.wd_clr;
endmodule // lcd_device_end
`default_nettype wire

// file: core/lcd_host_end.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module lcd_host_end (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   lcd_link_if.host link
);
   typedef enum logic [2:0] {
      H_IDLE, H_GAP, H_BIT_LO, H_BIT_HI, H_RD_LO, H_RD_HI, H_TURN
   } lcd_hphase_type;

   typedef struct packed {
      lcd_hphase_type ph;
      logic [3:0] tmr;
      logic [12:0] tx;
      logic [3:0] nbits;
      logic [2:0] nrd;
      logic [2:0] npost;
      logic [3:0] rx;
      logic [5:0] addr;
      logic [3:0] wdata;
      logic [8:0] cmd;
      lcd_pkg::lcd_op_type op;
      logic hold;
      logic held;
      logic busy;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic cs_n;
      logic wr_n;
      logic rd_n;
      logic dout;
      logic doe;
   } lcd_host_state_type;

   lcd_host_state_type r_reg;
   lcd_host_state_type r_next;
   logic din;
   logic access;
   logic half_done;
   lcd_pkg::lcd_op_type go_op;

   lcd_sync #(.W(1)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(link.data_line),
      .init(1'b1),
      .q(din)
   );

   function automatic logic addr_ok(input logic [7:0] a);
      return a == lcd_pkg::REG_ADDR || a == lcd_pkg::REG_DATA ||
             a == lcd_pkg::REG_CMD || a == lcd_pkg::REG_GO ||
             a == lcd_pkg::REG_STATUS;
   endfunction

   assign access = psel & penable & r_reg.pready;
   assign half_done = (r_reg.tmr == lcd_pkg::LINK_HALF_LAST);
   assign go_op = lcd_pkg::lcd_op_type'(pwdata[1:0]);

   always_comb begin
      r_next = r_reg;
      r_next.pready = psel & ~penable;
      r_next.pslverr = psel & ~penable & ~addr_ok(paddr);
      r_next.prdata = 32'h0000_0000;
      unique case (paddr)
         lcd_pkg::REG_ADDR: r_next.prdata[5:0] = r_reg.addr;
         lcd_pkg::REG_DATA: r_next.prdata[3:0] = r_reg.wdata;
         lcd_pkg::REG_CMD: r_next.prdata[8:0] = r_reg.cmd;
         lcd_pkg::REG_GO: r_next.prdata[2:0] = {r_reg.hold, r_reg.op};
         lcd_pkg::REG_STATUS: r_next.prdata[7:0] =
            {r_reg.rx, 2'h0, r_reg.held, r_reg.busy};
         default: r_next.prdata = 32'h0000_0000;
      endcase
      r_next.tmr = (r_reg.ph == H_IDLE || half_done) ? 4'h0 :
                   r_reg.tmr + 4'h1;
      if (access && pwrite) begin
         unique case (paddr)
            lcd_pkg::REG_ADDR: r_next.addr = pwdata[5:0];
            lcd_pkg::REG_DATA: r_next.wdata = pwdata[3:0];
            lcd_pkg::REG_CMD: r_next.cmd = pwdata[8:0];
            default: begin
            end
         endcase
      end
      unique case (r_reg.ph)
         H_IDLE: begin
            // a start while busy cannot happen: busy is only set here
            if (access && pwrite && paddr == lcd_pkg::REG_GO) begin
               r_next.op = go_op;
               r_next.hold = pwdata[lcd_pkg::GO_HOLD_BIT];
               r_next.busy = 1'b1;
               r_next.nrd = 3'h0;
               r_next.npost = 3'h0;
               r_next.tmr = 4'h0;
               unique case (go_op)
                  lcd_pkg::OP_WRITE: begin
                     r_next.tx = {lcd_pkg::ID_WRITE, r_reg.addr,
                        r_reg.wdata[0], r_reg.wdata[1], r_reg.wdata[2],
                        r_reg.wdata[3]};
                     r_next.nbits = 4'hD;
                  end
                  lcd_pkg::OP_READ: begin
                     r_next.tx = {lcd_pkg::ID_READ, r_reg.addr, 4'h0};
                     r_next.nbits = 4'h9;
                     r_next.nrd = 3'h4;
                  end
                  lcd_pkg::OP_RMW: begin
                     r_next.tx = {lcd_pkg::ID_WRITE, r_reg.addr,
                        r_reg.wdata[0], r_reg.wdata[1], r_reg.wdata[2],
                        r_reg.wdata[3]};
                     r_next.nbits = 4'h9;
                     r_next.nrd = 3'h4;
                     r_next.npost = 3'h4;
                  end
                  lcd_pkg::OP_CMD: begin
                     // the id is left out only when the previous command held the frame open
                     r_next.tx = r_reg.held ? {r_reg.cmd, 4'h0} :
                                 {lcd_pkg::ID_CMD, r_reg.cmd, 1'b0};
                     r_next.nbits = r_reg.held ? 4'h9 : 4'hC;
                  end
               endcase
               if (r_reg.held && go_op == lcd_pkg::OP_CMD) begin
                  r_next.ph = H_BIT_LO;
                  r_next.wr_n = 1'b0;
                  r_next.doe = 1'b1;
                  r_next.dout = r_reg.cmd[8];
               end else begin
                  // chip select high for a half period resets the decoder
                  r_next.ph = H_GAP;
                  r_next.cs_n = 1'b1;
                  r_next.held = 1'b0;
               end
            end
         end
         H_GAP: begin
            if (half_done) begin
               r_next.ph = H_BIT_LO;
               r_next.cs_n = 1'b0;
               r_next.wr_n = 1'b0;
               r_next.doe = 1'b1;
               r_next.dout = r_reg.tx[12];
            end
         end
         H_BIT_LO: begin
            if (half_done) begin
               r_next.ph = H_BIT_HI;
               r_next.wr_n = 1'b1;
            end
         end
         H_BIT_HI: begin
            if (half_done) begin
               r_next.tx = {r_reg.tx[11:0], 1'b0};
               r_next.nbits = r_reg.nbits - 4'h1;
               if (r_reg.nbits != 4'h1) begin
                  r_next.ph = H_BIT_LO;
                  r_next.wr_n = 1'b0;
                  r_next.dout = r_reg.tx[11];
               end else if (r_reg.nrd != 3'h0) begin
                  r_next.ph = H_RD_LO;
                  r_next.doe = 1'b0;
                  r_next.rd_n = 1'b0;
               end else begin
                  r_next.ph = H_IDLE;
                  r_next.busy = 1'b0;
                  r_next.doe = 1'b0;
                  r_next.held = r_reg.hold && r_reg.op == lcd_pkg::OP_CMD;
                  r_next.cs_n = ~(r_reg.hold && r_reg.op == lcd_pkg::OP_CMD);
               end
            end
         end
         H_RD_LO: begin
            if (half_done) begin
               r_next.ph = H_RD_HI;
               r_next.rd_n = 1'b1;
            end
         end
         H_RD_HI: begin
            if (half_done) begin
               // sampled late in the high half, before the next fall
               r_next.rx = {din, r_reg.rx[3:1]};
               r_next.nrd = r_reg.nrd - 3'h1;
               if (r_reg.nrd != 3'h1) begin
                  r_next.ph = H_RD_LO;
                  r_next.rd_n = 1'b0;
               end else if (r_reg.npost != 3'h0) begin
                  // turnaround: device lets go when it sees the strobe fall
                  r_next.ph = H_TURN;
                  r_next.wr_n = 1'b0;
                  r_next.nbits = {1'b0, r_reg.npost};
                  r_next.npost = 3'h0;
               end else begin
                  r_next.ph = H_IDLE;
                  r_next.busy = 1'b0;
                  r_next.cs_n = 1'b1;
               end
            end
         end
         H_TURN: begin
            if (half_done) begin
               r_next.ph = H_BIT_LO;
               r_next.doe = 1'b1;
               r_next.dout = r_reg.tx[12];
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
         r_reg.cs_n <= 1'b1;
         r_reg.wr_n <= 1'b1;
         r_reg.rd_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   assign link.cs_n = r_reg.cs_n;
   assign link.wr_n = r_reg.wr_n;
   assign link.rd_n = r_reg.rd_n;
   assign link.host_data_o = r_reg.dout;
   assign link.host_data_oe = r_reg.doe;
endmodule // lcd_host_end
`default_nettype wire

// file: core/lcd_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lcd_link_if;
   logic cs_n;
   logic wr_n;
   logic rd_n;
   logic host_data_o;
   logic host_data_oe;
   logic dev_data_o;
   logic dev_data_oe;
   logic data_line;

   // shared data wire with a pull-up when nobody drives
   assign data_line = dev_data_oe ? dev_data_o :
                      (host_data_oe ? host_data_o : 1'b1);

   modport host (output cs_n, output wr_n, output rd_n,
                 output host_data_o, output host_data_oe, input data_line);
   modport dev (input cs_n, input wr_n, input rd_n, input data_line,
                output dev_data_o, output dev_data_oe);
endinterface
`default_nettype wire

// file: core/lcd_pkg.sv
`default_nettype none
package lcd_pkg;
   // pclk 20 MHz; link strobes from the host end run at 400 ns period
   localparam int PCLK_PERIOD_NS = 50;
   localparam int LINK_HALF_NS = 200;
   localparam int LINK_HALF_CYC =
      (LINK_HALF_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
   localparam logic [3:0] LINK_HALF_LAST = 4'(LINK_HALF_CYC - 1);

   // frame mode ids
   localparam logic [2:0] ID_READ = 3'h6;
   localparam logic [2:0] ID_WRITE = 3'h5;
   localparam logic [2:0] ID_CMD = 3'h4;
   localparam logic [3:0] ID_LAST_BIT = 4'h2;
   localparam logic [3:0] ADDR_LAST_BIT = 4'h5;
   localparam logic [3:0] NIB_LAST_BIT = 4'h3;
   localparam logic [3:0] CMD_LAST_BIT = 4'h8;
   localparam logic [1:0] NIB_LAST_IDX = 2'h3;

   // command codes, upper eight bits of the nine-bit code
   localparam logic [7:0] CMD_SYS_OFF = 8'h00;
   localparam logic [7:0] CMD_OSC_ON = 8'h01;
   localparam logic [7:0] CMD_BIAS_OFF = 8'h02;
   localparam logic [7:0] CMD_BIAS_ON = 8'h03;
   localparam logic [7:0] CMD_TB_OFF = 8'h04;
   localparam logic [7:0] CMD_WD_OFF = 8'h05;
   localparam logic [7:0] CMD_TB_ON = 8'h06;
   localparam logic [7:0] CMD_WD_ON = 8'h07;
   localparam logic [7:0] CMD_TONE_OFF = 8'h08;
   localparam logic [7:0] CMD_TONE_ON = 8'h09;
   localparam logic [7:0] CMD_FACTORY = 8'hE0;
   localparam logic [7:0] CMD_NORMAL = 8'hE3;
   localparam logic [5:0] GRP_TB_CLEAR = 6'h03;
   localparam logic [6:0] GRP_WD_CLEAR = 7'h07;
   localparam logic [3:0] GRP_SOURCE = 4'h1;
   localparam logic [3:0] GRP_BIAS = 4'h2;
   localparam logic [2:0] GRP_TONE_HIGH = 3'h2;
   localparam logic [2:0] GRP_TONE_LOW = 3'h3;
   localparam logic [2:0] GRP_IRQ = 3'h4;
   localparam logic [2:0] GRP_RATE = 3'h5;

   // clock source and common count codes as carried in the command
   localparam logic [1:0] SRC_CRYSTAL = 2'h1;
   localparam logic [1:0] SRC_INTERNAL = 2'h2;
   localparam logic [1:0] SRC_EXTERNAL = 2'h3;
   localparam logic [1:0] COMMONS_TWO = 2'h0;
   localparam logic [1:0] COMMONS_BAD = 2'h3;

   typedef struct packed {
      logic osc_on;
      logic bias_on;
      logic tb_out_en;
      logic wd_flag_en;
      logic tone_on;
      logic tone_high;
      logic irq_en;
      logic bias_third;
      logic factory;
      logic [1:0] commons;
      logic [1:0] src;
      logic [2:0] rate;
   } lcd_cfg_type;

   localparam lcd_cfg_type CFG_RESET = '{
      osc_on: 1'b0, bias_on: 1'b0, tb_out_en: 1'b0, wd_flag_en: 1'b0,
      tone_on: 1'b0, tone_high: 1'b0, irq_en: 1'b0, bias_third: 1'b0,
      factory: 1'b0, commons: COMMONS_TWO, src: SRC_INTERNAL,
      rate: 3'h0};

   // host controller register map, byte addresses
   localparam logic [7:0] REG_ADDR = 8'h00;
   localparam logic [7:0] REG_DATA = 8'h04;
   localparam logic [7:0] REG_CMD = 8'h08;
   localparam logic [7:0] REG_GO = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam int GO_HOLD_BIT = 2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_HELD_BIT = 1;

   typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_RMW, OP_CMD} lcd_op_type;
endpackage
`default_nettype wire

// file: core/lcd_sync.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   input wire logic [W-1:0] init,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } lcd_sync_state_type;

   lcd_sync_state_type r_reg;
   lcd_sync_state_type r_next;

   always_comb begin
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
   end

   // idle level is all ones; init is masked off in q and never used, in reset or after
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign q = r_reg.s2 | (init & '0);
endmodule // lcd_sync
`default_nettype wire

// file: verification/lcd_link_props.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_link_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic host_data_o,
   input wire logic host_data_oe,
   input wire logic dev_data_o,
   input wire logic dev_data_oe
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence wr_low_s;
      !wr_n [*4] ##1 wr_n;
   endsequence
   sequence wr_turn_s;
      !wr_n [*8] ##1 wr_n;
   endsequence
   sequence rd_low_s;
      !rd_n [*4] ##1 rd_n;
   endsequence
   one_driver_a: assert property (!(host_data_oe && dev_data_oe))
      else $error("both ends drive the data line");
   idle_strobes_a: assert property (cs_n |-> (wr_n && rd_n))
      else $error("strobe active while deselected");
   wr_half_a: assert property ($fell(wr_n) && host_data_oe |-> wr_low_s)
      else $error("write strobe low half wrong");
   wr_turn_a: assert property ($fell(wr_n) && !host_data_oe |-> wr_turn_s)
      else $error("turnaround write strobe low time wrong");
   bit_hold_a: assert property ((!wr_n && !$past(wr_n) &&
      host_data_oe && $past(host_data_oe)) |-> $stable(host_data_o))
      else $error("host bit moved while write strobe low");
   rd_half_a: assert property ($fell(rd_n) |-> rd_low_s)
      else $error("read strobe low half wrong");
   rd_answer_a: assert property ($fell(rd_n) |-> ##[1:5] dev_data_oe)
      else $error("device did not answer read strobe");
   rd_no_host_a: assert property (!rd_n |-> !host_data_oe)
      else $error("host drives during read");
   release_a: assert property ($rose(cs_n) |-> ##[0:5] !dev_data_oe)
      else $error("device kept the line after deselect");
   read_hold_a: assert property ((rd_n && dev_data_oe &&
      $past(dev_data_oe)) |-> $stable(dev_data_o))
      else $error("read bit moved while read strobe high");
   gap_a: assert property ($rose(cs_n) |-> cs_n [*4])
      else $error("chip select gap too short");
endmodule // lcd_link_props
`default_nettype wire

// file: verification/tb_lcd_driver_serial_command_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module tb_lcd_driver_serial_command_decoder;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [5:0] disp_addr = 6'h00;
   logic [3:0] disp_nibble;
   lcd_pkg::lcd_cfg_type cfg;
   logic tb_clr;
   logic wd_clr;
   logic [31:0] rdata;
   logic err;
   int bad_count = 0;
   int comparisons = 0;
   int clr_n[2] = '{0, 0};
   int nbits = 0;
   logic [8:0] cmd_tab[23] = '{9'h002, 9'h006, 9'h00C, 9'h00E, 9'h012, 9'h080,
      9'h028, 9'h052, 9'h14E, 9'h110, 9'h008, 9'h00A, 9'h010, 9'h0C0, 9'h038,
      9'h1C0, 9'h1C6, 9'h004, 9'h000, 9'h030, 9'h100, 9'h018, 9'h01C};
   logic [15:0] cfg_tab[23] = '{16'h8010, 16'hC010, 16'hE010, 16'hF010,
      16'hF810, 16'hFC10, 16'hFC08, 16'hFD48, 16'hFD4F, 16'hFF4F, 16'hDF4F,
      16'hCF4F, 16'hC74F, 16'hC34F, 16'hC35F, 16'hC3DF, 16'hC35F, 16'h835F,
      16'h035F, 16'h0357, 16'h0157, 16'h0157, 16'h0157};
   lcd_link_if link_bus ();
   lcd_host_end i_lcd_host_end (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_bus));
   lcd_device_end i_lcd_device_end (.pclk(pclk), .presetn(presetn),
      .link(link_bus), .disp_addr(disp_addr), .disp_nibble(disp_nibble),
      .cfg(cfg), .timebase_clear(tb_clr), .watchdog_clear(wd_clr));
   lcd_link_props u_props (.pclk(pclk), .presetn(presetn),
      .cs_n(link_bus.cs_n), .wr_n(link_bus.wr_n), .rd_n(link_bus.rd_n),
      .host_data_o(link_bus.host_data_o), .host_data_oe(link_bus.host_data_oe),
      .dev_data_o(link_bus.dev_data_o), .dev_data_oe(link_bus.dev_data_oe));
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      if (tb_clr === 1'b1) clr_n[0]++;
      if (wd_clr === 1'b1) clr_n[1]++;
   end
   always @(posedge link_bus.wr_n) begin
      if (link_bus.cs_n === 1'b0) nbits++;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask
   // pready, read data and error are taken at the completing edge;
   // only the watchdog ends a wait that never gets an answer
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run(input logic [2:0] go);
      apb(1'b1, lcd_pkg::REG_GO, {29'h0, go});
      do apb(1'b0, lcd_pkg::REG_STATUS, 32'h0);
      while (rdata[0] !== 1'b0);
      repeat (4) @(posedge pclk);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(32'(cfg), 32'h0010);
      for (int i = 0; i < 23; i++) begin
         apb(1'b1, lcd_pkg::REG_CMD, {23'h0, cmd_tab[i]});
         run(3'h3);
         check(32'(cfg),
            {16'h0, cfg_tab[i]});
      end
      check(clr_n[0], 2);
      check(clr_n[1], 1);
      nbits = 0;
      apb(1'b1, lcd_pkg::REG_CMD, 32'h002);
      run(3'h7);
      apb(1'b1, lcd_pkg::REG_CMD, 32'h006);
      run(3'h3);
      check(nbits, 21);
      check(32'(cfg), 32'hC157);
      apb(1'b1, lcd_pkg::REG_CMD, 32'h000);
      run(3'h3);
      check(32'(cfg), 32'h0157);
      apb(1'b1, lcd_pkg::REG_ADDR, 32'h31);
      apb(1'b1, lcd_pkg::REG_DATA, 32'hA);
      run(3'h0);
      disp_addr <= 6'h31;
      run(3'h1);
      check(rdata[7:4], 4'hA);
      check(disp_nibble, 4'hA);
      apb(1'b1, lcd_pkg::REG_DATA, 32'h5);
      run(3'h2);
      check(rdata[7:4], 4'hA);
      check(disp_nibble, 4'h5);
      apb(1'b0, 8'h14, 32'h0);
      check({31'h0, err}, 32'h1);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check(32'(cfg), 32'h0010);
      check(disp_nibble, 4'h0);
      test_done();
   end
   initial begin
      #1_000_000;
      bad_count++;
      test_done();
   end
endmodule // tb_lcd_driver_serial_command_decoder
`default_nettype wire
